/* verilog/tzs_sequencer.sv */
// Track-zero sensor align sequencer: stepping, latency timing, offset and record
`timescale 1ns/1ps
module tzs_sequencer import tzs_pkg::*; #(
	parameter int SEEK_TIMEOUT = SEEK_TIMEOUT_CYC,
	parameter int PCT_LIMIT = 20
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic START_IN,
	input wire logic SENSOR_IN,
	input wire logic PRINT_TOGGLE_IN,
	input wire logic ROW_KEY_IN,
	output logic STEP_OUT,
	output logic DIR_IN_OUT,
	output logic ACTIVE_OUT,
	output logic [7:0] LEFT_FIELD_OUT,
	output logic signed [7:0] RIGHT_FIELD_OUT,
	output tzs_record_t RECORD_OUT,
	output logic RECORD_VALID_OUT
);
	logic sens_m_reg, sens_s_reg, sens_d_reg;
	tzs_state_t state_reg, state_next;
	logic [7:0] track_reg, track_next;
	logic dir_in_reg, dir_in_next;
	logic found_reg, found_next;
	logic step_next;
	logic [7:0] pulse_reg, pulse_next;
	logic [31:0] wait_reg, wait_next;
	logic [15:0] sub_reg, sub_next;
	logic [15:0] lat_reg, lat_next;
	logic [15:0] out_lat_reg, out_lat_next;
	logic [15:0] in_lat_reg, in_lat_next;
	logic have_out_reg, have_out_next;
	logic have_in_reg, have_in_next;
	logic print_en_reg, print_en_next;
	logic signed [7:0] pct_reg, pct_next;
	tzs_record_t rec_reg, rec_next;
	logic rec_v_next;
	logic sens_change;
	logic signed [17:0] diff;
	logic [15:0] big;
	logic [23:0] mag;
	logic [23:0] quot;

	assign sens_change = sens_s_reg ^ sens_d_reg;
	assign diff = $signed({2'b00, out_lat_reg}) - $signed({2'b00, in_lat_reg});
	assign big = (out_lat_reg > in_lat_reg) ? out_lat_reg : in_lat_reg;
	assign mag = diff[17] ? 24'(-diff) : 24'(diff);
	assign quot = (big == 16'h0000) ? 24'h000000 : (mag * 24'(PCT_SCALE)) / 24'(big);

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			sens_m_reg <= 1'b0;
			sens_s_reg <= 1'b0;
			sens_d_reg <= 1'b0;
		end else begin
			sens_m_reg <= SENSOR_IN;
			sens_s_reg <= sens_m_reg;
			sens_d_reg <= sens_s_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		track_next = track_reg;
		dir_in_next = dir_in_reg;
		found_next = found_reg;
		step_next = 1'b0;
		pulse_next = pulse_reg;
		wait_next = wait_reg;
		sub_next = sub_reg;
		lat_next = lat_reg;
		out_lat_next = out_lat_reg;
		in_lat_next = in_lat_reg;
		have_out_next = have_out_reg;
		have_in_next = have_in_reg;
		print_en_next = print_en_reg;
		pct_next = pct_reg;
		rec_next = rec_reg;
		rec_v_next = 1'b0;
		if (state_reg != TZS_IDLE && PRINT_TOGGLE_IN)
			print_en_next = !print_en_reg;
		case (state_reg)
			TZS_IDLE: begin
				if (START_IN) begin
					track_next = 8'hff;
					found_next = 1'b0;
					have_out_next = 1'b0;
					have_in_next = 1'b0;
					print_en_next = 1'b0;
					state_next = TZS_HOME;
				end
			end
			TZS_HOME: begin
				// Heads assumed parked at track 5; counting starts there
				track_next = START_TRACK;
				dir_in_next = 1'b0;
				found_next = 1'b0;
				pulse_next = 8'(STEP_PULSE_CYC);
				state_next = TZS_STEP;
			end
			TZS_STEP: begin
				step_next = 1'b1;
				pulse_next = pulse_reg - 8'h01;
				if (pulse_reg == 8'h01) begin
					wait_next = 32'(SEEK_TIMEOUT);
					state_next = TZS_WAIT;
				end
				if (sub_reg == 16'(TENTH_MS_CYC - 1)) begin
					sub_next = 16'h0000;
					lat_next = lat_reg + 16'h0001;
				end else
					sub_next = sub_reg + 16'h0001;
				// Leading edge restarts the latency clock, over any tick
				if (pulse_reg == 8'(STEP_PULSE_CYC)) begin
					sub_next = 16'h0000;
					lat_next = 16'h0000;
				end
			end
			TZS_WAIT: begin
				if (sub_reg == 16'(TENTH_MS_CYC - 1)) begin
					sub_next = 16'h0000;
					lat_next = lat_reg + 16'h0001;
				end else
					sub_next = sub_reg + 16'h0001;
				wait_next = wait_reg - 32'h1;
				pulse_next = 8'(STEP_PULSE_CYC);
				if (sens_change) begin
					found_next = 1'b1;
					if (dir_in_reg) begin
						in_lat_next = lat_reg;
						have_in_next = 1'b1;
						track_next = track_reg + 8'h01;
					end else begin
						out_lat_next = lat_reg;
						have_out_next = 1'b1;
						track_next = track_reg - 8'h01;
					end
					dir_in_next = !dir_in_reg;
					state_next = (have_in_reg || dir_in_reg) && (have_out_reg || !dir_in_reg)
						? TZS_CALC : TZS_STEP;
				end else if (wait_reg == 32'h1) begin
					if (dir_in_reg) begin
						track_next = track_reg + 8'h01;
						dir_in_next = 1'b0;
						state_next = TZS_STEP;
					end else if (found_reg) begin
						track_next = track_reg - 8'h01;
						dir_in_next = 1'b1;
						state_next = TZS_STEP;
					end else if (track_reg == 8'h01) begin
						state_next = TZS_HOME;
					end else begin
						track_next = track_reg - 8'h01;
						state_next = TZS_STEP;
					end
				end
			end
			TZS_CALC: begin
				pct_next = diff[17] ? -8'(quot) : 8'(quot);
				rec_next.offset_pct = diff[17] ? -8'(quot) : 8'(quot);
				rec_next.pct_pass = quot <= 24'(PCT_LIMIT);
				rec_next.from_track_field = dir_in_reg ? track_reg + 8'h01 : track_reg;
				rec_next.track_pass = 1'b1;
				rec_next.overall_pass = quot <= 24'(PCT_LIMIT);
				rec_next.step_out_latency = out_lat_reg;
				rec_next.step_in_latency = in_lat_reg;
				rec_v_next = print_en_reg;
				pulse_next = 8'(STEP_PULSE_CYC);
				state_next = TZS_STEP;
			end
			default: state_next = TZS_IDLE;
		endcase
		if (state_reg != TZS_IDLE && ROW_KEY_IN) begin
			state_next = TZS_IDLE;
			step_next = 1'b0;
			rec_v_next = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			state_reg <= TZS_IDLE;
			track_reg <= 8'h00;
			dir_in_reg <= 1'b0;
			found_reg <= 1'b0;
			pulse_reg <= 8'h00;
			wait_reg <= 32'h0;
			sub_reg <= 16'h0000;
			lat_reg <= 16'h0000;
			out_lat_reg <= 16'h0000;
			in_lat_reg <= 16'h0000;
			have_out_reg <= 1'b0;
			have_in_reg <= 1'b0;
			print_en_reg <= 1'b0;
			pct_reg <= 8'sh00;
			rec_reg <= '0;
		end else begin
			state_reg <= state_next;
			track_reg <= track_next;
			dir_in_reg <= dir_in_next;
			found_reg <= found_next;
			pulse_reg <= pulse_next;
			wait_reg <= wait_next;
			sub_reg <= sub_next;
			lat_reg <= lat_next;
			out_lat_reg <= out_lat_next;
			in_lat_reg <= in_lat_next;
			have_out_reg <= have_out_next;
			have_in_reg <= have_in_next;
			print_en_reg <= print_en_next;
			pct_reg <= pct_next;
			rec_reg <= rec_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			STEP_OUT <= 1'b0;
			DIR_IN_OUT <= 1'b0;
			ACTIVE_OUT <= 1'b0;
			LEFT_FIELD_OUT <= 8'h00;
			RIGHT_FIELD_OUT <= 8'sh00;
			RECORD_OUT <= '0;
			RECORD_VALID_OUT <= 1'b0;
		end else begin
			STEP_OUT <= step_next;
			DIR_IN_OUT <= dir_in_next;
			ACTIVE_OUT <= state_next != TZS_IDLE;
			LEFT_FIELD_OUT <= rec_next.from_track_field;
			RIGHT_FIELD_OUT <= pct_next;
			RECORD_OUT <= rec_next;
			RECORD_VALID_OUT <= rec_v_next;
		end
	end
endmodule // tzs_sequencer

/* common/tzs_pkg.sv */
// Package of constants and types for the track-zero sensor align sequencer
package tzs_pkg;
	localparam logic [7:0] START_TRACK = 8'h05;
	localparam int CLK_HZ = 25000000;
	localparam int STEP_PULSE_NS = 1000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int TENTH_MS_CYC = CLK_HZ / 10000;
	localparam int SEEK_TIMEOUT_MS = 30;
	localparam int SEEK_TIMEOUT_CYC = SEEK_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam logic [7:0] PCT_SCALE = 8'h64;

	typedef enum logic [2:0] {
		TZS_IDLE = 3'b000,
		TZS_HOME = 3'b001,
		TZS_STEP = 3'b010,
		TZS_WAIT = 3'b011,
		TZS_CALC = 3'b100,
		TZS_DONE = 3'b101
	} tzs_state_t;

	typedef struct packed {
		logic overall_pass;
		logic pct_pass;
		logic track_pass;
		logic signed [7:0] offset_pct;
		logic [7:0] from_track_field;
		logic [15:0] step_in_latency;
		logic [15:0] step_out_latency;
	} tzs_record_t;
endpackage

/* sim/tzs_properties.sv */
// Port checker for the sequencer
`timescale 1ns/1ps
module tzs_properties import tzs_pkg::*; (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic START_IN,
	input wire logic ROW_KEY_IN,
	input wire logic STEP_OUT,
	input wire logic DIR_IN_OUT,
	input wire logic ACTIVE_OUT,
	input wire logic [7:0] LEFT_FIELD_OUT,
	input wire logic signed [7:0] RIGHT_FIELD_OUT,
	input wire tzs_record_t RECORD_OUT,
	input wire logic RECORD_VALID_OUT
);
	logic [7:0] hi_reg;
	logic [7:0] hi_next;
	assign hi_next = STEP_OUT ? hi_reg + 8'h01 : 8'h00;
	always_ff @(posedge CLK_IN) hi_reg <= hi_next;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	sequence s_start;
		START_IN && !ACTIVE_OUT;
	endsequence
	sequence s_first_out;
		##[1:4] (STEP_OUT && !DIR_IN_OUT);
	endsequence
	AST_START_OUT: assert property (s_start |-> s_first_out)
		else $error("no first step out");
	AST_STEP_WIDTH: assert property ($fell(STEP_OUT) && !$past(ROW_KEY_IN) |-> hi_reg == 8'h19)
		else $error("step width");
	AST_DIR_HOLD: assert property (STEP_OUT && $past(STEP_OUT) |-> $stable(DIR_IN_OUT))
		else $error("dir moved in pulse");
	AST_IDLE_QUIET: assert property ((!ACTIVE_OUT && !START_IN) [*3] |-> !$rose(STEP_OUT))
		else $error("step while idle");
	AST_ROW_REC: assert property (ACTIVE_OUT && ROW_KEY_IN |-> ##[1:2] RECORD_VALID_OUT)
		else $error("no final record");
	AST_ROW_END: assert property (ACTIVE_OUT && ROW_KEY_IN |-> ##[1:3] !ACTIVE_OUT)
		else $error("test not ended");
	AST_IDLE_KEY: assert property (!ACTIVE_OUT && ROW_KEY_IN |=> !RECORD_VALID_OUT [*2])
		else $error("record while idle");
	AST_VALID_PULSE: assert property (RECORD_VALID_OUT && !(ACTIVE_OUT && ROW_KEY_IN) |=> !RECORD_VALID_OUT)
		else $error("valid too long");
	AST_SIGN: assert property (RECORD_VALID_OUT && RECORD_OUT.offset_pct != 0 |->
		(RECORD_OUT.offset_pct > 0) == (RECORD_OUT.step_out_latency > RECORD_OUT.step_in_latency))
		else $error("offset sign");
	AST_FIELDS: assert property (RECORD_VALID_OUT |->
		RECORD_OUT.from_track_field == LEFT_FIELD_OUT && RECORD_OUT.offset_pct == RIGHT_FIELD_OUT)
		else $error("record vs display");
endmodule // tzs_properties
bind tzs_sequencer tzs_properties chk (.CLK_IN, .RESETN_IN, .START_IN, .ROW_KEY_IN, .STEP_OUT,
	.DIR_IN_OUT, .ACTIVE_OUT, .LEFT_FIELD_OUT, .RIGHT_FIELD_OUT, .RECORD_OUT, .RECORD_VALID_OUT);

/* sim/tzs_drive_model.sv */
// Drive under test: head position and track-zero sensor
`timescale 1ns/1ps
module tzs_drive_model #(
	parameter int OUT_DLY = 1000,
	parameter int IN_DLY = 1000,
	parameter logic [7:0] EDGE_TRK = 8'h02
) (
	input wire logic clk_in,
	input wire logic step_in,
	input wire logic dir_in,
	output logic sensor_out
);
	logic [7:0] trk_reg = 8'h05;
	logic [7:0] trk_next;
	logic step_reg = 1'b0;
	logic lvl_reg = 1'b0;
	int wait_reg = 0;
	initial sensor_out = 1'b0;
	assign trk_next = dir_in ? trk_reg + 8'h01 : trk_reg - 8'h01;
	always @(posedge clk_in) begin
		step_reg <= step_in;
		if (step_in && !step_reg) begin
			trk_reg <= trk_next;
			lvl_reg <= trk_next < EDGE_TRK;
			wait_reg <= dir_in ? IN_DLY : OUT_DLY;
		end else if (wait_reg > 0) begin
			wait_reg <= wait_reg - 1;
			if (wait_reg == 1) sensor_out <= lvl_reg;
		end
	end
endmodule // tzs_drive_model

/* sim/tb.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module tb import tzs_pkg::*;;
	localparam int OUT_DLY = 4 * TENTH_MS_CYC + 100;
	localparam int IN_DLY = 2 * TENTH_MS_CYC + 100;
	logic clk, rstn, start, sens, ptog, rowk, step, dir, act, vld, rnd_on;
	logic [7:0] left;
	logic signed [7:0] right;
	tzs_record_t rec;
	logic [31:0] rnd;
	int mismatches, samples_checked, n, exp_off;
	int lat_q[$];
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	tzs_sequencer #(.SEEK_TIMEOUT(12000)) uut (.CLK_IN(clk), .RESETN_IN(rstn), .START_IN(start),
		.SENSOR_IN(sens), .PRINT_TOGGLE_IN(ptog), .ROW_KEY_IN(rowk), .STEP_OUT(step),
		.DIR_IN_OUT(dir), .ACTIVE_OUT(act), .LEFT_FIELD_OUT(left), .RIGHT_FIELD_OUT(right),
		.RECORD_OUT(rec), .RECORD_VALID_OUT(vld));
	tzs_drive_model #(.OUT_DLY(OUT_DLY), .IN_DLY(IN_DLY)) drv (.clk_in(clk), .step_in(step),
		.dir_in(dir), .sensor_out(sens));
	task automatic tick;
		@(negedge clk);
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		start = rnd_on & rnd[0];
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %0d seen %0d", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic bound(input int lim);
		if (n >= lim) begin
			mismatches++;
			$display("[ERR] wait_limit exp 1 seen 0");
			complete_run;
		end
	endtask
	initial begin
		{rstn, start, ptog, rowk, rnd_on} = 5'h00;
		rnd = 32'h00005737;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		rowk = 1'b1;
		tick;
		rowk = 1'b0;
		start = 1'b1;
		tick;
		tick;
		check("active", act, 1);
		rnd_on = 1'b1;
		for (n = 0; n < 80000 && right === 8'sh00; n++) tick;
		bound(80000);
		rnd_on = 1'b0;
		lat_q = {OUT_DLY / TENTH_MS_CYC, IN_DLY / TENTH_MS_CYC};
		exp_off = (lat_q[0] - lat_q[1]) * 100 / (lat_q[0] > lat_q[1] ? lat_q[0] : lat_q[1]);
		check("left", left, 2);
		check("right", right, exp_off);
		$display("search test done");
		ptog = 1'b1;
		tick;
		ptog = 1'b0;
		for (n = 0; n < 40000 && vld !== 1'b1; n++) tick;
		bound(40000);
		check("rec_track", rec.from_track_field, 2);
		check("rec_off", rec.offset_pct, exp_off);
		check("rec_out", rec.step_out_latency, lat_q[0]);
		check("rec_in", rec.step_in_latency, lat_q[1]);
		check("rec_pass", rec.pct_pass, 0);
		$display("print test done");
		rowk = 1'b1;
		tick;
		rowk = 1'b0;
		for (n = 0; n < 4 && vld !== 1'b1; n++) tick;
		bound(4);
		check("final_off", rec.offset_pct, exp_off);
		repeat (3) tick;
		check("active_end", act, 0);
		$display("exit test done");
		complete_run;
	end
endmodule // tb
